// ===== design/lcd_mode_command_status.sv
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
module lcd_mode_command_status #(
    parameter int unsigned FRAME_CYCLES = 2000000,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // write address channel
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [ADDR_W-1:0] s_awaddr,
    input wire logic [2:0] s_awprot,
    // write data channel
    input wire logic s_wvalid,
    output logic s_wready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    // write response channel
    output logic s_bvalid,
    input wire logic s_bready,
    output logic [1:0] s_bresp,
    // read address channel
    input wire logic s_arvalid,
    output logic s_arready,
    input wire logic [ADDR_W-1:0] s_araddr,
    input wire logic [2:0] s_arprot,
    // read data channel
    output logic s_rvalid,
    input wire logic s_rready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    // panel drive controls
    output lcd_mode_pkg::drive_t drive
);
    // register index of a byte address, 3'h7 when unmapped
    function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
        logic [7:0] b;
        b = a[7:0];
        if (b == lcd_mode_pkg::ofs_cmd) return 3'h0;
        else if (b == lcd_mode_pkg::ofs_rdata) return 3'h1;
        else if (b == lcd_mode_pkg::ofs_status) return 3'h2;
        else if (b == lcd_mode_pkg::ofs_drive) return 3'h3;
        else if (b == lcd_mode_pkg::ofs_frame) return 3'h4;
        else return 3'h7;
    endfunction

    // byte lane merge for writable words
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (st[i])
            begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // write channel holding registers
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] rd_mux;
    logic [1:0] rd_resp;

    // interpreter state
    logic [7:0] param_cmd;
    logic param_wait;
    logic rd_active;
    logic [2:0] rd_idx;
    logic [31:0] rd_snap;
    lcd_mode_pkg::mode_t mode_req;
    lcd_mode_pkg::mode_t mode_act;
    lcd_mode_pkg::access_t acc;
    logic [2:0] pixfmt;
    logic [2:0] gamma;
    logic [6:0] contrast;
    logic booster;
    lcd_mode_pkg::sleep_state_t state;
    lcd_mode_pkg::sleep_state_t next_state;
    logic [1:0] frames_left;
    logic [31:0] frame_len;
    logic [31:0] frame_cnt;

    // decode of the write that has both halves in hand
    wire wr_fire = aw_held && w_held && !s_bvalid;
    wire [2:0] wr_sel = reg_sel(aw_addr);
    wire rd_fire = s_arvalid && s_arready;
    wire [2:0] rd_sel = reg_sel(s_araddr);
    wire byte_in = wr_fire && wr_sel == 3'h0 && w_strb[0];
    wire in_dc = w_data[lcd_mode_pkg::dc_bit];
    wire [7:0] in_byte = w_data[7:0];
    wire cmd_in = byte_in && !in_dc;
    wire par_in = byte_in && in_dc && param_wait;
    wire soft_rst = cmd_in && in_byte == lcd_mode_pkg::soft_reset_cmd;
    wire any_rst = reset || soft_rst;
    wire rd_pop = rd_fire && rd_sel == 3'h1;

    // frame timing, stopped while the oscillator is off
    wire osc_on = state != lcd_mode_pkg::st_asleep;
    wire frame_tick = osc_on && frame_cnt >= frame_len - 32'h1;
    // with no frames running there is nothing to wait for, so modes apply at once
    wire apply_now = frame_tick || !osc_on;
    wire sleep_out = state != lcd_mode_pkg::st_asleep;
    wire boost_status = booster && sleep_out;

    // assembled status word
    wire [31:0] status_word = {
        boost_status,
        acc.page_ord, acc.col_ord,
        acc.pc_dir,
        acc.line_ord,
        acc.bgr,
        2'b00,
        acc.com_rev,
        pixfmt,
        mode_act.idle, mode_act.partial,
        sleep_out, mode_act.normal,
        mode_act.scroll, 1'b0, mode_act.invert,
        mode_act.all_on, mode_act.all_off, mode_act.disp_on,
        1'b0, // undefined bit reads zero
        gamma,
        6'h00
    };

    // status read byte stream, dummy byte first
    wire [7:0] stream_byte = !rd_active ? 8'h00 :
        (rd_idx == 3'h0) ? lcd_mode_pkg::dummy_byte :
        rd_snap[(3'(lcd_mode_pkg::status_bytes - rd_idx)) * 8 +: 8];

    // drive word as panel logic sees it
    wire [31:0] drive_word = {16'h0000, 9'(drive[15:7]), drive.contrast};

    // register read selection
    assign rd_mux = (rd_sel == 3'h1) ? {24'h000000, stream_byte} :
        (rd_sel == 3'h2) ? status_word :
        (rd_sel == 3'h3) ? drive_word :
        (rd_sel == 3'h4) ? frame_len : 32'h00000000;
    assign rd_resp = (rd_sel == 3'h7) ? lcd_mode_pkg::resp_slverr : lcd_mode_pkg::resp_okay;

    // one write and one read in flight at a time
    assign s_awready = !aw_held && !s_bvalid;
    assign s_wready = !w_held && !s_bvalid;
    assign s_arready = !s_rvalid;

    // write address and data, taken in either order
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_bvalid <= 1'b0;
            s_bresp <= lcd_mode_pkg::resp_okay;
        end
        else
        begin
            if (s_awvalid && s_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_awaddr;
            end
            if (s_wvalid && s_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_wdata;
                w_strb <= s_wstrb;
            end
            if (wr_fire)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= (wr_sel == 3'h7) ? lcd_mode_pkg::resp_slverr : lcd_mode_pkg::resp_okay;
            end
            else if (s_bvalid && s_bready)
            begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // read answer one cycle after the address is taken
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s_rvalid <= 1'b0;
            s_rdata <= 32'h00000000;
            s_rresp <= lcd_mode_pkg::resp_okay;
        end
        else if (rd_fire)
        begin
            s_rvalid <= 1'b1;
            s_rdata <= rd_mux;
            s_rresp <= rd_resp;
        end
        else if (s_rvalid && s_rready)
        begin
            s_rvalid <= 1'b0;
        end
    end

    // frame length, software tunable; never below one cycle
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            frame_len <= FRAME_CYCLES;
        end
        else if (wr_fire && wr_sel == 3'h4)
        begin
            frame_len <= (merge(frame_len, w_data, w_strb) == 32'h0) ? 32'h1 : merge(frame_len, w_data, w_strb);
        end
    end

    // frame divider
    always_ff @(posedge clk)
    begin
        if (reset || !osc_on || frame_tick)
        begin
            frame_cnt <= 32'h00000000;
        end
        else
        begin
            frame_cnt <= frame_cnt + 32'h1;
        end
    end

    // command and parameter tracking, status read pointer
    always_ff @(posedge clk)
    begin
        if (any_rst)
        begin
            param_cmd <= 8'h00;
            param_wait <= 1'b0;
            rd_active <= 1'b0;
            rd_idx <= 3'h0;
            rd_snap <= 32'h00000000;
        end
        else if (cmd_in)
        begin
            param_cmd <= in_byte;
            param_wait <= in_byte == lcd_mode_pkg::contrast_write_cmd || in_byte == lcd_mode_pkg::access_ctrl_cmd
                || in_byte == lcd_mode_pkg::pixel_format_cmd || in_byte == lcd_mode_pkg::gamma_select_cmd
                || in_byte == lcd_mode_pkg::scroll_start_cmd;
            // any new command ends a status read in progress
            rd_active <= in_byte == lcd_mode_pkg::status_read_cmd;
            rd_idx <= 3'h0;
            rd_snap <= status_word;
        end
        else
        begin
            if (par_in)
            begin
                param_wait <= 1'b0;
            end
            if (rd_pop && rd_active)
            begin
                rd_idx <= rd_idx + 3'h1;
                rd_active <= rd_idx != lcd_mode_pkg::status_bytes;
            end
        end
    end

    // settings that act as soon as their parameter lands
    always_ff @(posedge clk)
    begin
        if (any_rst)
        begin
            acc <= '0;
            pixfmt <= lcd_mode_pkg::pixfmt_12bit;
            gamma <= lcd_mode_pkg::gamma_set_zero;
            contrast <= lcd_mode_pkg::contrast_rst;
        end
        else if (par_in)
        begin
            case (param_cmd)
                lcd_mode_pkg::contrast_write_cmd: contrast <= in_byte[6:0];
                lcd_mode_pkg::access_ctrl_cmd: acc <= access_t_of(in_byte);
                lcd_mode_pkg::pixel_format_cmd: pixfmt <= in_byte[2:0];
                lcd_mode_pkg::gamma_select_cmd: gamma <= in_byte[2:0];
                default: contrast <= contrast;
            endcase
        end
    end

    // access control parameter layout, top six bits
    function automatic lcd_mode_pkg::access_t access_t_of(input logic [7:0] p);
        return lcd_mode_pkg::access_t'(p[7:2]);
    endfunction

    // requested modes; held until the next frame boundary, applied at once while asleep
    always_ff @(posedge clk)
    begin
        if (any_rst)
        begin
            mode_req <= lcd_mode_pkg::mode_rst;
        end
        else if (par_in && param_cmd == lcd_mode_pkg::scroll_start_cmd)
        begin
            mode_req.scroll <= 1'b1;
        end
        else if (cmd_in)
        begin
            case (in_byte)
                lcd_mode_pkg::partial_on_cmd:
                begin
                    mode_req.partial <= 1'b1;
                    mode_req.normal <= 1'b0;
                    mode_req.all_on <= 1'b0;
                    mode_req.all_off <= 1'b0;
                end
                lcd_mode_pkg::normal_display_cmd:
                begin
                    mode_req.partial <= 1'b0;
                    mode_req.normal <= 1'b1;
                    mode_req.scroll <= 1'b0;
                    mode_req.all_on <= 1'b0;
                    mode_req.all_off <= 1'b0;
                end
                lcd_mode_pkg::invert_off_cmd: mode_req.invert <= 1'b0;
                lcd_mode_pkg::invert_on_cmd: mode_req.invert <= 1'b1;
                lcd_mode_pkg::all_off_cmd:
                begin
                    mode_req.all_off <= 1'b1;
                    mode_req.all_on <= 1'b0;
                end
                lcd_mode_pkg::all_on_cmd:
                begin
                    mode_req.all_on <= 1'b1;
                    mode_req.all_off <= 1'b0;
                end
                lcd_mode_pkg::display_off_cmd: mode_req.disp_on <= 1'b0;
                lcd_mode_pkg::display_on_cmd: mode_req.disp_on <= 1'b1;
                lcd_mode_pkg::idle_off_cmd: mode_req.idle <= 1'b0;
                lcd_mode_pkg::idle_on_cmd: mode_req.idle <= 1'b1;
                default: mode_req <= mode_req;
            endcase
        end
    end

    // active modes and their status bits change together at the frame start, or at once while asleep
    always_ff @(posedge clk)
    begin
        if (any_rst)
        begin
            mode_act <= lcd_mode_pkg::mode_rst;
        end
        else if (apply_now)
        begin
            mode_act <= mode_req;
        end
    end

    // booster: sleep transitions plus the independent on/off commands
    always_ff @(posedge clk)
    begin
        if (any_rst)
        begin
            booster <= 1'b0;
        end
        else if (next_state == lcd_mode_pkg::st_asleep && state != lcd_mode_pkg::st_asleep)
        begin
            booster <= 1'b0;
        end
        else if (cmd_in && (in_byte == lcd_mode_pkg::sleep_exit_cmd || in_byte == lcd_mode_pkg::booster_on_cmd))
        begin
            booster <= 1'b1;
        end
        else if (cmd_in && in_byte == lcd_mode_pkg::booster_off_cmd)
        begin
            booster <= 1'b0;
        end
    end

    // sleep sequencer next state
    always_comb
    begin
        next_state = state;
        case (state)
            lcd_mode_pkg::st_asleep:
            begin
                if (cmd_in && in_byte == lcd_mode_pkg::sleep_exit_cmd)
                begin
                    next_state = mode_act.disp_on ? lcd_mode_pkg::st_waking : lcd_mode_pkg::st_awake;
                end
            end
            lcd_mode_pkg::st_waking:
            begin
                if (cmd_in && in_byte == lcd_mode_pkg::sleep_enter_cmd)
                begin
                    next_state = lcd_mode_pkg::st_entering;
                end
                else if (frame_tick && frames_left == 2'h1)
                begin
                    next_state = lcd_mode_pkg::st_awake;
                end
            end
            lcd_mode_pkg::st_awake:
            begin
                if (cmd_in && in_byte == lcd_mode_pkg::sleep_enter_cmd)
                begin
                    // a dark panel has nothing to fade, so it sleeps at once
                    next_state = mode_act.disp_on ? lcd_mode_pkg::st_entering : lcd_mode_pkg::st_asleep;
                end
            end
            lcd_mode_pkg::st_entering:
            begin
                if (frame_tick && frames_left == 2'h1)
                begin
                    next_state = lcd_mode_pkg::st_asleep;
                end
            end
            default: next_state = lcd_mode_pkg::st_asleep;
        endcase
    end

    // sleep sequencer state and frame countdown
    always_ff @(posedge clk)
    begin
        if (any_rst)
        begin
            state <= lcd_mode_pkg::st_asleep;
            frames_left <= 2'h0;
        end
        else
        begin
            state <= next_state;
            if (next_state == lcd_mode_pkg::st_waking && state != lcd_mode_pkg::st_waking)
            begin
                frames_left <= lcd_mode_pkg::wake_frames;
            end
            else if (next_state == lcd_mode_pkg::st_entering && state != lcd_mode_pkg::st_entering)
            begin
                // three boundaries put entry between two and three frames out
                frames_left <= lcd_mode_pkg::enter_frames;
            end
            else if (frame_tick && frames_left != 2'h0)
            begin
                frames_left <= frames_left - 2'h1;
            end
        end
    end

    // registered panel controls
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            drive <= '0;
            drive.mid_drive_level <= 1'b1;
            drive.contrast <= lcd_mode_pkg::contrast_rst;
        end
        else
        begin
            drive.mid_drive_level <= state != lcd_mode_pkg::st_awake;
            drive.power_on <= boost_status;
            drive.osc_on <= osc_on;
            drive.visible <= mode_act.disp_on && state == lcd_mode_pkg::st_awake;
            drive.force_off <= mode_act.all_off;
            drive.force_on <= mode_act.all_on;
            drive.invert <= mode_act.invert;
            drive.partial <= mode_act.partial;
            drive.idle <= mode_act.idle;
            drive.contrast <= contrast;
        end
    end
endmodule

// ===== design/lcd_mode_pkg.sv
package lcd_mode_pkg;
    // register byte offsets
    localparam logic [7:0] ofs_cmd = 8'h00;
    localparam logic [7:0] ofs_rdata = 8'h04;
    localparam logic [7:0] ofs_status = 8'h08;
    localparam logic [7:0] ofs_drive = 8'h0C;
    localparam logic [7:0] ofs_frame = 8'h10;
    localparam int dc_bit = 8;
    // command codes
    localparam logic [7:0] soft_reset_cmd = 8'h01;
    localparam logic [7:0] booster_off_cmd = 8'h02;
    localparam logic [7:0] booster_on_cmd = 8'h03;
    localparam logic [7:0] status_read_cmd = 8'h09;
    localparam logic [7:0] sleep_enter_cmd = 8'h10;
    localparam logic [7:0] sleep_exit_cmd = 8'h11;
    localparam logic [7:0] partial_on_cmd = 8'h12;
    localparam logic [7:0] normal_display_cmd = 8'h13;
    localparam logic [7:0] invert_off_cmd = 8'h20;
    localparam logic [7:0] invert_on_cmd = 8'h21;
    localparam logic [7:0] all_off_cmd = 8'h22;
    localparam logic [7:0] all_on_cmd = 8'h23;
    localparam logic [7:0] contrast_write_cmd = 8'h25;
    localparam logic [7:0] display_off_cmd = 8'h28;
    localparam logic [7:0] display_on_cmd = 8'h29;
    localparam logic [7:0] access_ctrl_cmd = 8'h36;
    localparam logic [7:0] scroll_start_cmd = 8'h37;
    localparam logic [7:0] idle_off_cmd = 8'h38;
    localparam logic [7:0] idle_on_cmd = 8'h39;
    localparam logic [7:0] pixel_format_cmd = 8'h3A;
    localparam logic [7:0] gamma_select_cmd = 8'hB5;
    // field values and reset values
    localparam logic [6:0] contrast_rst = 7'h3F;
    localparam logic [2:0] pixfmt_8bit = 3'h2;
    localparam logic [2:0] pixfmt_12bit = 3'h3;
    localparam logic [2:0] gamma_set_zero = 3'h0;
    localparam logic [2:0] gamma_set_one = 3'h1;
    localparam logic [7:0] dummy_byte = 8'h00;
    localparam logic [2:0] status_bytes = 3'h4;
    localparam logic [1:0] wake_frames = 2'h2;
    localparam logic [1:0] enter_frames = 2'h3;
    localparam logic [1:0] resp_okay = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;

    typedef struct packed {
        logic idle;
        logic partial;
        logic normal;
        logic scroll;
        logic invert;
        logic all_on;
        logic all_off;
        logic disp_on;
    } mode_t;
    localparam mode_t mode_rst = mode_t'(8'h20);

    typedef struct packed {
        logic page_ord;
        logic col_ord;
        logic pc_dir;
        logic line_ord;
        logic bgr;
        logic com_rev;
    } access_t;

    typedef struct packed {
        logic mid_drive_level;
        logic power_on;
        logic osc_on;
        logic visible;
        logic force_off;
        logic force_on;
        logic invert;
        logic partial;
        logic idle;
        logic [6:0] contrast;
    } drive_t;

    typedef enum logic [1:0] {
        st_asleep = 2'b00,
        st_waking = 2'b01,
        st_awake = 2'b10,
        st_entering = 2'b11
    } sleep_state_t;
endpackage

// ===== verif/lcd_host.sv
module lcd_host
(
    // clock
    input wire logic clk,
    // write side
    output logic awvalid,
    input wire logic awready,
    output logic [7:0] awaddr,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    input wire logic bvalid,
    output logic bready,
    input wire logic [1:0] bresp,
    // read side
    output logic arvalid,
    input wire logic arready,
    output logic [7:0] araddr,
    input wire logic rvalid,
    output logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus from time zero
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
    end
    // address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        while (pa | pw)
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            pa = pa & !awready;
            pw = pw & !wready;
        end
        while (!bvalid) @(posedge clk);
        r = bresp;
        bready <= 1'b0;
    endtask
    // rready held up until the answer is sampled
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
endmodule

// ===== verif/lcd_mode_command_status_chk.sv
module lcd_mode_chk
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // bus handshakes
    input wire logic s_awvalid,
    input wire logic s_awready,
    input wire logic s_wvalid,
    input wire logic s_wready,
    input wire logic s_bvalid,
    input wire logic s_bready,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic s_rvalid,
    input wire logic s_rready,
    input wire logic [31:0] s_rdata,
    // panel drive
    input wire lcd_mode_pkg::drive_t drive
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff reset;
    chk_read_turn: assert property (s_arvalid && s_arready |=> s_rvalid)
        else $error("read answer late");
    chk_read_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read answer dropped");
    chk_read_block: assert property (s_rvalid |-> !s_arready)
        else $error("read taken while busy");
    chk_write_turn: assert property (s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid)
        else $error("write answer late");
    chk_write_hold: assert property (s_bvalid && !s_bready |=> s_bvalid)
        else $error("write answer dropped");
    chk_reset_drive: assert property ($fell(reset) |-> drive.mid_drive_level && drive.contrast == 7'h3F)
        else $error("drive not at reset values");
    chk_power_awake: assert property (drive.power_on |-> drive.osc_on)
        else $error("power shown while asleep");
    chk_dark_asleep: assert property (drive.visible |-> !drive.mid_drive_level)
        else $error("picture shown at mid level");
    cov_wake: cover property ($rose(drive.power_on));
    cov_show: cover property ($rose(drive.visible));
    cov_read: cover property (s_rvalid && s_rready);
endmodule

bind lcd_mode_command_status lcd_mode_chk u_chk
(
    .clk, .reset, .s_awvalid, .s_awready, .s_wvalid, .s_wready, .s_bvalid, .s_bready,
    .s_arvalid, .s_arready, .s_rvalid, .s_rready, .s_rdata, .drive
);

// ===== verif/test_lcd_mode_command_status.sv
module test_lcd_mode_command_status;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rv;
    logic [1:0] bresp, rresp, rs;
    lcd_mode_pkg::drive_t drive;
    int errors, n_checks, cycles;
    // stand-in for the host's long settle wait after a dark wake; the block does not time it
    localparam int wake_gap = 64;
    logic [7:0] cmds [7];
    logic [31:0] stats [7];
    logic [39:0] seq;

    lcd_mode_command_status #(.FRAME_CYCLES(16)) u_dut
    (
        .clk(clk), .reset(reset), .s_awvalid(awvalid), .s_awready(awready), .s_awaddr(awaddr),
        .s_awprot(3'h0), .s_wvalid(wvalid), .s_wready(wready), .s_wdata(wdata), .s_wstrb(4'hF),
        .s_bvalid(bvalid), .s_bready(bready), .s_bresp(bresp), .s_arvalid(arvalid), .s_arready(arready),
        .s_araddr(araddr), .s_arprot(3'h0), .s_rvalid(rvalid), .s_rready(rready), .s_rdata(rdata),
        .s_rresp(rresp), .drive(drive)
    );
    lcd_host u_host
    (
        .clk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .bvalid, .bready, .bresp,
        .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp
    );
    // clock and hang guard
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            errors++;
            final_report();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cmd(input logic [8:0] b);
        u_host.wr(lcd_mode_pkg::ofs_cmd, {23'h0, b}, rs);
    endtask
    task automatic stat(input logic [31:0] e);
        u_host.rd(lcd_mode_pkg::ofs_status, rv, rs);
        check("status", rv, e);
    endtask
    task automatic final_report();
        if (errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // main sequence, mode table runs while asleep so effects land at once
    initial
    begin
        {reset, errors, n_checks, cycles} = {1'b1, 96'h0};
        cmds = '{8'h21, 8'h20, 8'h12, 8'h23, 8'h13, 8'h22, 8'h13};
        stats = '{32'h00312000, 32'h00310000, 32'h00340000, 32'h00341000, 32'h00310000, 32'h00310800, 32'h00310000};
        seq = 40'h0000310000;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        stat(32'h00310000);
        check("drive", 32'(drive), 32'h0000803F);
        cmd(9'h009);
        for (int i = 0; i < 5; i++)
        begin
            u_host.rd(lcd_mode_pkg::ofs_rdata, rv, rs);
            check("status byte", rv, {24'h0, seq[39 - 8 * i -: 8]});
        end
        for (int i = 0; i < 2; i++)
        begin
            cmd(9'h025);
            cmd({1'b1, i ? 8'h00 : 8'h7F});
            // drive register follows the setting one edge later
            @(posedge clk);
            check("contrast", 32'(drive.contrast), i ? 32'h0 : 32'h7F);
        end
        for (int i = 0; i < 7; i++)
        begin
            cmd({1'b0, cmds[i]});
            stat(stats[i]);
        end
        cmd(9'h011);
        stat(32'h80330000);
        repeat (wake_gap) @(posedge clk);
        cmd(9'h029);
        repeat (40) @(posedge clk);
        stat(32'h80330400);
        cmd(9'h010);
        @(posedge clk);
        check("mid level", 32'(drive.mid_drive_level), 32'h1);
        stat(32'h80330400);
        repeat (50) @(posedge clk);
        stat(32'h00310400);
        check("drive", 32'(drive), 32'h00008000);
        cmd(9'h011);
        check("visible", 32'(drive.visible), 32'h0);
        repeat (48) @(posedge clk);
        check("visible", 32'(drive.visible), 32'h1);
        u_host.wr(lcd_mode_pkg::ofs_status, 32'hFFFFFFFF, rs);
        check("ro resp", 32'(rs), 32'(lcd_mode_pkg::resp_okay));
        stat(32'h80330400);
        u_host.rd(8'h40, rv, rs);
        check("bad read", {rv[29:0], rs}, 32'(lcd_mode_pkg::resp_slverr));
        u_host.wr(8'h40, 32'h0, rs);
        check("bad write", 32'(rs), 32'(lcd_mode_pkg::resp_slverr));
        // settings no earlier step touches, then a soft reset back to defaults
        cmd(9'h036);
        cmd(9'h1FC);
        cmd(9'h03A);
        cmd(9'h102);
        cmd(9'h0B5);
        cmd(9'h101);
        cmd(9'h039);
        cmd(9'h037);
        cmd(9'h100);
        repeat (20) @(posedge clk);
        stat(32'hFCAB8440);
        u_host.rd(lcd_mode_pkg::ofs_drive, rv, rs);
        check("drive reg", rv, 32'h00007080);
        u_host.wr(lcd_mode_pkg::ofs_frame, 32'h0, rs);
        u_host.rd(lcd_mode_pkg::ofs_frame, rv, rs);
        check("frame len", rv, 32'h00000001);
        cmd(9'h001);
        stat(32'h00310000);
        final_report();
    end
endmodule
